//--- hw/hpg_pkg.sv
// Constants for the two-channel host port with fast gate decoder.
// Behaviour
// R1 - Port works only while host_port_enable, bit 1 of system_control_reg, is set.
// R2 - Channel-one read: command/data low gives out register one, high gives status one.
// R3 - Channel-one write loads input register one as data or command.
// R4 - Channel-two read: command/data low gives out register two, high gives status two.
// R5 - Channel-two write loads input register two as data or command.
// R6 - Host never asserts both strobes; with both low nothing is accessed.
// R7 - Gate pin is hardware driven only while fast_gate_enable, control bit 0, is set.
// R8 - In regular mode software copies data bit 1 after a D1 command.
// R9 - Software sets gate_pin_direction before the fast gate drives the pin.
// R10 - Fast gate starts with logic 1 from the port data reset value.
// R11 - Only channel-one writes to input register one feed the gate decoder.
// R12 - Data after D1 sets or clears the gate from bit 1 at write end.
// R13 - D1, FF and data after D1 raise no CPU flag; other commands do.
// R14 - Other command after D1 cancels and flags; repeated D1 stays armed.
// R15 - Full interrupt per channel while input register full and its enable set.
// R16 - Port-four bits 3, 4, 5 are request latches, set by read 0 then write 1.
// R17 - Host read of out register one clears bits 4 and 5 on read fall.
// R18 - Host read of out register two clears bit 3 on read fall.
// R19 - CPU writing 0 to a port-four bit clears that request latch.
// R20 - Write end latches host data and command/data line into the channel.
// R21 - Input full set by host write, cleared by CPU read of the register.
// R22 - Output full set by CPU write, cleared at end of host read.
package hpg_pkg;
    // Register byte addresses
    localparam logic [15:0] ADDR_HOST_PORT_CONTROL = 16'hfff0;
    localparam logic [15:0] ADDR_SYSTEM_CONTROL = 16'hffc4;
    localparam logic [15:0] ADDR_IN_ONE = 16'hfff4;
    localparam logic [15:0] ADDR_OUT_ONE = 16'hfff8;
    localparam logic [15:0] ADDR_STATUS_ONE = 16'hfffc;
    localparam logic [15:0] ADDR_IN_TWO = 16'hffe4;
    localparam logic [15:0] ADDR_OUT_TWO = 16'hffe8;
    localparam logic [15:0] ADDR_STATUS_TWO = 16'hffec;
    localparam logic [15:0] ADDR_PORT4_DATA = 16'hffb8;
    localparam logic [15:0] ADDR_PORT8_DATA = 16'hffbc;
    localparam logic [15:0] ADDR_PORT8_DIR = 16'hffc0;
    // Field positions
    localparam int HOST_PORT_ENABLE_BIT = 1;
    localparam int FAST_GATE_ENABLE_BIT = 0;
    localparam int CHAN1_IRQ_ENABLE_BIT = 1;
    localparam int CHAN2_IRQ_ENABLE_BIT = 2;
    localparam int GATE_PIN_BIT = 1;
    localparam int ST_CMD_BIT = 3;
    localparam int ST_IN_FULL_BIT = 1;
    localparam int ST_OUT_FULL_BIT = 0;
    localparam logic [7:0] ST_USER_MASK = 8'hf4;
    localparam int REQ_AUX_BIT = 3;
    localparam int REQ_FIRST_BIT = 4;
    localparam int REQ_SECOND_BIT = 5;
    // Reset values
    localparam logic [7:0] HOST_PORT_CONTROL_RST = 8'h00;
    localparam logic [7:0] SYSTEM_CONTROL_RST = 8'h00;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] PORT4_RST = 8'h00;
    localparam logic [7:0] PORT8_DATA_RST = 8'h02;
    localparam logic [7:0] PORT8_DIR_RST = 8'h00;
    // Gate decoder commands
    localparam logic [7:0] CMD_GATE = 8'hd1;
    localparam logic [7:0] CMD_NOP = 8'hff;
    // Sampled host pin bundle width
    localparam int PIN_W = 13;
endpackage : hpg_pkg

//--- hw/hpg_sync.sv
// Two-stage synchroniser for the asynchronous host pins.
`timescale 1ns/10ps
`default_nettype none
module hpg_sync
    import hpg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [PIN_W-1:0] pin_in,
    output logic [PIN_W-1:0] pin_out
);
    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
    } hpg_sync_st_t;

    hpg_sync_st_t st_q;
    hpg_sync_st_t st_d;

    // Idle pins read high (strobes and selects inactive)
    always_comb begin
        st_d = st_q;
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '1;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_out = st_q.s2;
endmodule : hpg_sync
`default_nettype wire

//--- hw/hpg_gate_dec.sv
// Fast gate command decoder watching channel-one input writes.
`timescale 1ns/10ps
`default_nettype none
module hpg_gate_dec
    import hpg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic wr_stb,
    input wire logic wr_cmd,
    input wire logic [7:0] wr_data,
    output logic gate_load,
    output logic gate_val,
    output logic irq_quiet
);
    typedef struct packed {
        logic armed;
    } hpg_gate_st_t;

    hpg_gate_st_t st_q;
    hpg_gate_st_t st_d;

    // Arm on D1, disarm on data or any other command
    always_comb begin
        st_d = st_q;
        gate_load = 1'b0;
        gate_val = wr_data[GATE_PIN_BIT];
        irq_quiet = 1'b0;
        if (!enable) begin
            st_d.armed = 1'b0;
        end else if (wr_stb) begin
            if (wr_cmd) begin
                st_d.armed = (wr_data == CMD_GATE); // see R14
                irq_quiet = (wr_data == CMD_GATE) || (wr_data == CMD_NOP); // see R13
            end else begin
                st_d.armed = 1'b0;
                gate_load = st_q.armed; // see R12
                irq_quiet = st_q.armed; // see R13
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : hpg_gate_dec
`default_nettype wire

//--- hw/hpg_top.sv
// Two-channel host port with APB register access and fast gate output.
`timescale 1ns/10ps
`default_nettype none
module hpg_top
    import hpg_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic chan1_select_n,
    input wire logic chan2_select_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic host_cmd_data_line,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    output logic chan1_full_irq,
    output logic chan2_full_irq,
    output logic host_req_aux,
    output logic host_req_first,
    output logic host_req_second,
    output logic host_req_oe,
    output logic gate_output_pin,
    output logic gate_output_oe
);
    // Synchronised pin bundle layout
    typedef struct packed {
        logic cs1_n;
        logic cs2_n;
        logic rd_n;
        logic wr_n;
        logic ha0;
        logic [7:0] data;
    } hpg_pins_t;

    typedef struct packed {
        hpg_pins_t prev;
        logic [7:0] sys_ctl;
        logic [7:0] hp_ctl;
        logic [7:0] in_one;
        logic [7:0] in_two;
        logic [7:0] out_one;
        logic [7:0] out_two;
        logic [7:0] st_one;
        logic [7:0] st_two;
        logic [7:0] p4;
        logic [2:0] p4_zero;
        logic [7:0] p8;
        logic [7:0] p8_dir;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] hd_out;
        logic hd_oe;
        logic irq1;
        logic irq2;
        logic [2:0] hreq;
        logic hreq_oe;
        logic gate;
        logic gate_oe;
    } hpg_top_st_t;

    hpg_top_st_t st_q;
    hpg_top_st_t st_d;
    hpg_pins_t pins;
    logic [PIN_W-1:0] pins_raw;
    logic dec_load;
    logic dec_val;
    logic dec_quiet;
    logic wr1_stb;
    logic wr1_cmd;

    // Access on one channel: own select low, other select high
    function automatic logic chan_sel(input hpg_pins_t p, input logic two);
        chan_sel = two ? (!p.cs2_n && p.cs1_n) : (!p.cs1_n && p.cs2_n);
    endfunction : chan_sel

    // Address is one of the mapped registers
    function automatic logic addr_ok(input logic [15:0] a);
        addr_ok = (a == ADDR_HOST_PORT_CONTROL) || (a == ADDR_SYSTEM_CONTROL) ||
                  (a == ADDR_IN_ONE) || (a == ADDR_OUT_ONE) || (a == ADDR_STATUS_ONE) ||
                  (a == ADDR_IN_TWO) || (a == ADDR_OUT_TWO) || (a == ADDR_STATUS_TWO) ||
                  (a == ADDR_PORT4_DATA) || (a == ADDR_PORT8_DATA) ||
                  (a == ADDR_PORT8_DIR);
    endfunction : addr_ok

    // Two-flop capture of every host pin
    hpg_sync u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({chan1_select_n, chan2_select_n, host_read_strobe_n, host_write_strobe_n,
                 host_cmd_data_line, host_data_in}),
        .pin_out(pins_raw)
    );

    assign pins = hpg_pins_t'(pins_raw);

    // Channel-one write seen by the gate decoder only
    assign wr1_stb = st_q.sys_ctl[HOST_PORT_ENABLE_BIT] && !st_q.prev.wr_n && pins.wr_n &&
                     st_q.prev.rd_n && chan_sel(st_q.prev, 1'b0); // see R11
    assign wr1_cmd = st_q.prev.ha0;

    hpg_gate_dec u_gate_dec (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(st_q.hp_ctl[FAST_GATE_ENABLE_BIT]), // see R7
        .wr_stb(wr1_stb),
        .wr_cmd(wr1_cmd),
        .wr_data(st_q.prev.data),
        .gate_load(dec_load),
        .gate_val(dec_val),
        .irq_quiet(dec_quiet)
    );

    // Next-state logic: host events, APB access, derived outputs
    always_comb begin
        logic host_port_enable;
        logic wr_end;
        logic rd_fall;
        logic rd_end;
        logic acc;
        logic apb_wr;
        logic apb_rd;
        logic [7:0] wb;
        logic [31:0] rword;
        logic [2:0] req_set;
        logic [2:0] req_clr;
        host_port_enable = st_q.sys_ctl[HOST_PORT_ENABLE_BIT];
        wr_end = 1'b0;
        rd_fall = 1'b0;
        rd_end = 1'b0;
        acc = psel && penable && st_q.pready;
        apb_wr = acc && pwrite && addr_ok(paddr);
        apb_rd = acc && !pwrite && addr_ok(paddr);
        wb = pwdata[7:0];
        rword = 32'h0000_0000;
        req_set = 3'b000;
        req_clr = 3'b000;
        st_d = st_q;
        st_d.prev = pins;

        // Host strobe edges, valid only with one strobe active
        wr_end = host_port_enable && !st_q.prev.wr_n && pins.wr_n && st_q.prev.rd_n; // see R6
        rd_end = host_port_enable && !st_q.prev.rd_n && pins.rd_n && st_q.prev.wr_n; // see R6
        rd_fall = host_port_enable && st_q.prev.rd_n && !pins.rd_n && pins.wr_n; // see R6

        // Host data reads release the output buffer at read end
        if (rd_end && !st_q.prev.ha0 && chan_sel(st_q.prev, 1'b0)) begin
            st_d.st_one[ST_OUT_FULL_BIT] = 1'b0; // see R22
        end
        if (rd_end && !st_q.prev.ha0 && chan_sel(st_q.prev, 1'b1)) begin
            st_d.st_two[ST_OUT_FULL_BIT] = 1'b0; // see R22
        end

        // Host data read start clears request latches
        if (rd_fall && !pins.ha0 && chan_sel(pins, 1'b0)) begin
            req_clr[1] = 1'b1; // see R17
            req_clr[2] = 1'b1; // see R17
        end
        if (rd_fall && !pins.ha0 && chan_sel(pins, 1'b1)) begin
            req_clr[0] = 1'b1; // see R18
        end

        // Fast gate update from the decoder
        if (dec_load) begin
            st_d.p8[GATE_PIN_BIT] = dec_val; // see R12
        end

        // APB reads and their side effects
        if (apb_rd) begin
            unique case (paddr)
                ADDR_IN_ONE: begin
                    st_d.st_one[ST_IN_FULL_BIT] = 1'b0; // see R21
                end
                ADDR_IN_TWO: begin
                    st_d.st_two[ST_IN_FULL_BIT] = 1'b0; // see R21
                end
                ADDR_PORT4_DATA: begin
                    st_d.p4_zero = st_q.p4_zero |
                        ~{st_q.p4[REQ_SECOND_BIT], st_q.p4[REQ_FIRST_BIT],
                          st_q.p4[REQ_AUX_BIT]}; // see R16
                end
                default: begin
                end
            endcase
        end

        // Host writes latch data; full set wins over a same-cycle read clear
        if (wr_end && chan_sel(st_q.prev, 1'b0)) begin
            st_d.in_one = st_q.prev.data; // see R3
            st_d.st_one[ST_CMD_BIT] = st_q.prev.ha0; // see R20
            if (!dec_quiet) begin
                st_d.st_one[ST_IN_FULL_BIT] = 1'b1; // see R21
            end
        end
        if (wr_end && chan_sel(st_q.prev, 1'b1)) begin
            st_d.in_two = st_q.prev.data; // see R5
            st_d.st_two[ST_CMD_BIT] = st_q.prev.ha0; // see R20
            st_d.st_two[ST_IN_FULL_BIT] = 1'b1; // see R21
        end

        // APB writes
        if (apb_wr) begin
            unique case (paddr)
                ADDR_HOST_PORT_CONTROL: st_d.hp_ctl = wb;
                ADDR_SYSTEM_CONTROL: st_d.sys_ctl = wb;
                ADDR_OUT_ONE: begin
                    st_d.out_one = wb;
                    st_d.st_one[ST_OUT_FULL_BIT] = 1'b1; // see R22
                end
                ADDR_OUT_TWO: begin
                    st_d.out_two = wb;
                    st_d.st_two[ST_OUT_FULL_BIT] = 1'b1; // see R22
                end
                ADDR_STATUS_ONE: begin
                    st_d.st_one = (st_d.st_one & ~ST_USER_MASK) | (wb & ST_USER_MASK);
                end
                ADDR_STATUS_TWO: begin
                    st_d.st_two = (st_d.st_two & ~ST_USER_MASK) | (wb & ST_USER_MASK);
                end
                ADDR_PORT4_DATA: begin
                    st_d.p4 = wb;
                    req_set = st_q.p4_zero & {wb[REQ_SECOND_BIT], wb[REQ_FIRST_BIT],
                                              wb[REQ_AUX_BIT]}; // see R16
                    req_clr = req_clr | ~{wb[REQ_SECOND_BIT], wb[REQ_FIRST_BIT],
                                          wb[REQ_AUX_BIT]}; // see R19
                    st_d.p4_zero = 3'b000;
                end
                ADDR_PORT8_DATA: begin
                    st_d.p8 = wb;
                    if (dec_load) begin
                        st_d.p8[GATE_PIN_BIT] = dec_val; // see R12
                    end
                end
                ADDR_PORT8_DIR: st_d.p8_dir = wb;
                default: begin
                end
            endcase
        end

        // Request latches: a set in the same cycle wins over a clear
        st_d.p4[REQ_AUX_BIT] = req_set[0] ||
            (st_q.p4[REQ_AUX_BIT] && !req_clr[0] && !(apb_wr && paddr == ADDR_PORT4_DATA));
        st_d.p4[REQ_FIRST_BIT] = req_set[1] ||
            (st_q.p4[REQ_FIRST_BIT] && !req_clr[1] && !(apb_wr && paddr == ADDR_PORT4_DATA));
        st_d.p4[REQ_SECOND_BIT] = req_set[2] ||
            (st_q.p4[REQ_SECOND_BIT] && !req_clr[2] && !(apb_wr && paddr == ADDR_PORT4_DATA));

        // Read data mux for the access phase
        unique case (paddr)
            ADDR_HOST_PORT_CONTROL: rword[7:0] = st_q.hp_ctl;
            ADDR_SYSTEM_CONTROL: rword[7:0] = st_q.sys_ctl;
            ADDR_IN_ONE: rword[7:0] = st_q.in_one;
            ADDR_OUT_ONE: rword[7:0] = st_q.out_one;
            ADDR_STATUS_ONE: rword[7:0] = st_q.st_one;
            ADDR_IN_TWO: rword[7:0] = st_q.in_two;
            ADDR_OUT_TWO: rword[7:0] = st_q.out_two;
            ADDR_STATUS_TWO: rword[7:0] = st_q.st_two;
            ADDR_PORT4_DATA: rword[7:0] = st_q.p4;
            ADDR_PORT8_DATA: rword[7:0] = st_q.p8;
            ADDR_PORT8_DIR: rword[7:0] = st_q.p8_dir;
            default: rword = 32'h0000_0000;
        endcase

        // One wait-free access cycle after every setup cycle
        st_d.pready = psel && !penable;
        st_d.pslverr = psel && !penable && !addr_ok(paddr);
        st_d.prdata = (psel && !penable && !pwrite) ? rword : 32'h0000_0000;

        // Host data bus drive while a read is held
        st_d.hd_oe = 1'b0;
        st_d.hd_out = 8'h00;
        if (host_port_enable && !pins.rd_n && pins.wr_n) begin
            if (chan_sel(pins, 1'b0)) begin
                st_d.hd_oe = 1'b1; // see R1
                st_d.hd_out = pins.ha0 ? st_q.st_one : st_q.out_one; // see R2
            end else if (chan_sel(pins, 1'b1)) begin
                st_d.hd_oe = 1'b1; // see R1
                st_d.hd_out = pins.ha0 ? st_q.st_two : st_q.out_two; // see R4
            end
        end

        // Interrupts to the on-chip CPU
        st_d.irq1 = host_port_enable && st_d.st_one[ST_IN_FULL_BIT] &&
                    st_q.hp_ctl[CHAN1_IRQ_ENABLE_BIT]; // see R15
        st_d.irq2 = host_port_enable && st_d.st_two[ST_IN_FULL_BIT] &&
                    st_q.hp_ctl[CHAN2_IRQ_ENABLE_BIT]; // see R15

        // Host request lines owned by the port in slave mode
        st_d.hreq = {st_d.p4[REQ_SECOND_BIT], st_d.p4[REQ_FIRST_BIT], st_d.p4[REQ_AUX_BIT]};
        st_d.hreq_oe = host_port_enable; // see R1

        // Gate pin follows port data; direction bit enables the driver
        st_d.gate = st_d.p8[GATE_PIN_BIT]; // see R10
        st_d.gate_oe = st_d.p8_dir[GATE_PIN_BIT]; // see R9
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
            st_q.prev <= '1;
            st_q.sys_ctl <= SYSTEM_CONTROL_RST;
            st_q.hp_ctl <= HOST_PORT_CONTROL_RST;
            st_q.in_one <= DATA_RST;
            st_q.in_two <= DATA_RST;
            st_q.out_one <= DATA_RST;
            st_q.out_two <= DATA_RST;
            st_q.st_one <= STATUS_RST;
            st_q.st_two <= STATUS_RST;
            st_q.p4 <= PORT4_RST;
            st_q.p8 <= PORT8_DATA_RST; // see R10
            st_q.p8_dir <= PORT8_DIR_RST;
            st_q.gate <= PORT8_DATA_RST[GATE_PIN_BIT];
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign host_data_out = st_q.hd_out;
    assign host_data_oe = st_q.hd_oe;
    assign chan1_full_irq = st_q.irq1;
    assign chan2_full_irq = st_q.irq2;
    assign host_req_aux = st_q.hreq[0];
    assign host_req_first = st_q.hreq[1];
    assign host_req_second = st_q.hreq[2];
    assign host_req_oe = st_q.hreq_oe;
    assign gate_output_pin = st_q.gate;
    assign gate_output_oe = st_q.gate_oe;
endmodule : hpg_top
`default_nettype wire

//--- sim/hpg_top_asserts.sv
// Checker watching the host port top module ports.
`timescale 1ns/10ps
`default_nettype none
module hpg_top_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic chan1_select_n,
    input wire logic chan2_select_n,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    input wire logic chan1_full_irq,
    input wire logic chan2_full_irq,
    input wire logic host_req_oe,
    input wire logic gate_output_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Bus answer timing
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready");
    a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
        else $error("stray pready");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not idle");
    a_rdata_upper_zero: assert property (prdata[31:8] == 24'h0)
        else $error("prdata upper set");
    // Host side behaviour
    a_off_port_quiet: assert property (!host_req_oe |-> !host_data_oe && !chan1_full_irq && !chan2_full_irq)
        else $error("disabled port active");
    a_idle_no_drive: assert property ((chan1_select_n && chan2_select_n) [*5] |-> !host_data_oe)
        else $error("drive unselected");
    a_both_strobes_off: assert property ((!host_read_strobe_n && !host_write_strobe_n) [*5] |-> !host_data_oe)
        else $error("drive on both strobes");
    a_data_out_quiet: assert property (!host_data_oe |-> host_data_out == 8'h00)
        else $error("data out not idle");
    a_gate_hold_idle: assert property ((host_write_strobe_n && !(psel && pwrite)) [*6] |=> $stable(gate_output_pin))
        else $error("gate moved");
endmodule : hpg_top_asserts
bind hpg_top hpg_top_asserts u_chk (.*);
`default_nettype wire

//--- sim/hpg_host_model.sv
// Behavioural host processor on the parallel host bus.
`timescale 1ns/10ps
`default_nettype none
module hpg_host_model (
    input wire logic clk,
    input wire logic [7:0] dout,
    input wire logic oe,
    output logic cs1_n,
    output logic cs2_n,
    output logic rd_n,
    output logic wr_n,
    output logic ha0,
    output logic [7:0] dq
);
    // Idle bus at time zero
    initial {cs1_n, cs2_n, rd_n, wr_n, ha0, dq} = 13'h1e00;
    // Select channel and command line
    task automatic pick(input int ch, input logic ha);
        cs1_n <= (ch != 1);
        cs2_n <= (ch != 2);
        ha0 <= ha;
    endtask : pick
    // Release selects, flip stale data
    task automatic drop();
        cs1_n <= 1'b1;
        cs2_n <= 1'b1;
        dq <= ~dq;
        repeat (6) @(posedge clk);
    endtask : drop
    // Host write cycle; both gives the illegal two-strobe cycle
    task automatic hwrite(input int ch, input logic ha, input logic [7:0] d,
        input logic both = 1'b0);
        @(posedge clk);
        pick(ch, ha);
        dq <= d;
        rd_n <= !both;
        wr_n <= 1'b0;
        repeat (4) @(posedge clk);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (2) @(posedge clk);
        drop();
    endtask : hwrite
    // Host read cycle
    task automatic hread(input int ch, input logic ha, output logic [7:0] d, output logic o);
        @(posedge clk);
        pick(ch, ha);
        rd_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        d = dout;
        o = oe;
        @(posedge clk);
        rd_n <= 1'b1;
        repeat (2) @(posedge clk);
        drop();
    endtask : hread
endmodule : hpg_host_model
`default_nettype wire

//--- sim/hpg_top_tb_top.sv
// Self-checking bench for the host port with fast gate output.
`timescale 1ns/10ps
`default_nettype none
module hpg_top_tb_top
    import hpg_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] paddr = 16'h0000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, re, ho, c1, c2, rdn, wrn, ha, doe, rq_a, rq_f, rq_s, rq_oe, g, g_oe;
    logic [7:0] hdi, hdo, hd;
    logic ir1, ir2;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    // Gate steps: chan, cmd, data, gate, full
    logic [19:0] seq [14] = '{20'h11d12, 20'h10000, 20'h11ff0, 20'h11d10, 20'h10022, 20'h11aa3,
        20'h11d12, 20'h11553, 20'h10003, 20'h11d12, 20'h11d12, 20'h10000, 20'h21d11, 20'h20021};
    hpg_top dut (.clk, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .chan1_select_n(c1), .chan2_select_n(c2), .host_read_strobe_n(rdn),
        .host_write_strobe_n(wrn), .host_cmd_data_line(ha), .host_data_in(hdi),
        .host_data_out(hdo), .host_data_oe(doe), .chan1_full_irq(ir1), .chan2_full_irq(ir2),
        .host_req_aux(rq_a), .host_req_first(rq_f), .host_req_second(rq_s),
        .host_req_oe(rq_oe), .gate_output_pin(g), .gate_output_oe(g_oe));
    hpg_host_model u_host (.clk, .dout(hdo), .oe(doe), .cs1_n(c1), .cs2_n(c2),
        .rd_n(rdn), .wr_n(wrn), .ha0(ha), .dq(hdi));
    // Clock and hang limit
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        checks_done++;
        if (v !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
        output logic [31:0] d, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        d = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : apb
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rv, re);
    endtask : wr
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, rv, re);
        chk($sformatf("reg %h", a), {24'h0, e}, rv);
    endtask : rdc
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("gate", 1, g);
        rdc(ADDR_HOST_PORT_CONTROL, 8'h00);
        rdc(ADDR_PORT8_DATA, 8'h02);
        rdc(ADDR_STATUS_TWO, 8'h00);
        apb(1'b0, 16'h0000, 32'h0, rv, re);
        chk("unmapped err", 1, re);
        chk("unmapped data", 0, rv);
        $display("test reset done");
        u_host.hwrite(1, 1'b0, 8'h77);
        rdc(ADDR_STATUS_ONE, 8'h00);
        wr(ADDR_SYSTEM_CONTROL, 8'h02);
        chk("req oe", 1, rq_oe);
        wr(ADDR_HOST_PORT_CONTROL, 8'h06);
        u_host.hwrite(1, 1'b0, 8'h5a);
        rdc(ADDR_STATUS_ONE, 8'h02);
        chk("irq1", 1, ir1);
        rdc(ADDR_IN_ONE, 8'h5a);
        rdc(ADDR_STATUS_ONE, 8'h00);
        u_host.hwrite(2, 1'b1, 8'h3c);
        rdc(ADDR_STATUS_TWO, 8'h0a);
        chk("irq2", 1, ir2);
        wr(ADDR_HOST_PORT_CONTROL, 8'h02);
        chk("irq2 masked", 0, ir2);
        rdc(ADDR_IN_TWO, 8'h3c);
        wr(ADDR_HOST_PORT_CONTROL, 8'h06);
        $display("test host write done");
        wr(ADDR_STATUS_ONE, 8'hf4);
        wr(ADDR_OUT_ONE, 8'ha5);
        rdc(ADDR_STATUS_ONE, 8'hf5);
        u_host.hread(1, 1'b1, hd, ho);
        chk("status one", 8'hf5, hd);
        u_host.hread(1, 1'b0, hd, ho);
        chk("out one", 8'ha5, hd);
        chk("drive", 1, ho);
        rdc(ADDR_STATUS_ONE, 8'hf4);
        wr(ADDR_OUT_TWO, 8'h69);
        u_host.hread(2, 1'b0, hd, ho);
        chk("out two", 8'h69, hd);
        u_host.hread(2, 1'b1, hd, ho);
        chk("status two", 8'h08, hd);
        wr(ADDR_OUT_ONE, 8'h11);
        u_host.hwrite(1, 1'b0, 8'h11, 1'b1);
        rdc(ADDR_STATUS_ONE, 8'hf5);
        $display("test host read done");
        rdc(ADDR_PORT4_DATA, 8'h00);
        wr(ADDR_PORT4_DATA, 8'h38);
        chk("req set", 3'b111, {rq_a, rq_f, rq_s});
        u_host.hread(1, 1'b0, hd, ho);
        chk("req one read", 3'b100, {rq_a, rq_f, rq_s});
        u_host.hread(2, 1'b0, hd, ho);
        chk("req two read", 3'b000, {rq_a, rq_f, rq_s});
        rdc(ADDR_PORT4_DATA, 8'h00);
        wr(ADDR_PORT4_DATA, 8'h38);
        wr(ADDR_PORT4_DATA, 8'h00);
        chk("req cpu clear", 3'b000, {rq_a, rq_f, rq_s});
        wr(ADDR_PORT4_DATA, 8'h38);
        chk("req no read", 3'b000, {rq_a, rq_f, rq_s});
        $display("test request latch done");
        wr(ADDR_PORT8_DIR, 8'h02);
        chk("gate oe", 1, g_oe);
        u_host.hwrite(1, 1'b1, CMD_GATE);
        u_host.hwrite(1, 1'b0, 8'h00);
        chk("gate slow", 1, g);
        rdc(ADDR_IN_ONE, 8'h00);
        wr(ADDR_PORT8_DATA, 8'h00);
        chk("gate soft", 0, g);
        wr(ADDR_PORT8_DATA, 8'h02);
        wr(ADDR_HOST_PORT_CONTROL, 8'h07);
        chk("gate start", 1, g);
        for (int i = 0; i < 14; i++) begin
            u_host.hwrite(seq[i][19:16], seq[i][12], seq[i][11:4]);
            chk("gate", seq[i][1], g);
            chk("full", seq[i][0], seq[i][16] ? ir1 : ir2);
            if (seq[i][0]) begin
                apb(1'b0, seq[i][16] ? ADDR_IN_ONE : ADDR_IN_TWO, 32'h0, rv, re);
            end
        end
        $display("test fast gate done");
        results();
    end
endmodule : hpg_top_tb_top
`default_nettype wire
